// [core/script_decode_regs.vh]
// Field positions, encodings and reset values of the script decoder
`ifndef SCRIPT_DECODE_REGS_VH
`define SCRIPT_DECODE_REGS_VH

// Instruction type field and its value for both decoded classes
`define TYPE_HI        31
`define TYPE_LO        30
`define TYPE_IO_RW     2'h1

// Opcode field and its values
`define OPC_HI         29
`define OPC_LO         27
`define OPC_SELECT     3'h0
`define OPC_DISCON     3'h1
`define OPC_WAIT_SEL   3'h2
`define OPC_SET        3'h3
`define OPC_CLEAR      3'h4
`define OPC_FROM_FBR   3'h5
`define OPC_TO_FBR     3'h6
`define OPC_RMW        3'h7

// I/O class field positions
`define BIT_REL        26
`define BIT_TABLE      25
`define BIT_SEL_ATN    24
`define DEST_ID_HI     18
`define DEST_ID_LO     16
`define BIT_CARRY      10
`define BIT_TARGET     9
`define BIT_ACK        6
`define BIT_ATN        3
`define OFS_HI         23
`define OFS_SIGN       23

// Read/write class field positions
`define ALU_OP_HI      26
`define ALU_OP_LO      24
`define REG_ADDR_HI    22
`define REG_ADDR_LO    16
`define IMM_HI         15
`define IMM_LO         8

// Operator encodings
`define ALU_LOAD       3'h0
`define ALU_SHL        3'h1
`define ALU_OR         3'h2
`define ALU_XOR        3'h3
`define ALU_AND        3'h4
`define ALU_SHR        3'h5
`define ALU_ADD        3'h6
`define ALU_ADDC       3'h7

// Selection table entry byte lanes
`define TBL_CFG_HI     7
`define TBL_CFG_LO     0
`define TBL_ID_HI      10
`define TBL_ID_LO      8
`define TBL_XFER_HI    23
`define TBL_XFER_LO    16

// Reset values
`define RST_BYTE       8'h00
`define RST_WORD       32'h00000000

`endif

// [core/reg_byte_file.v]
// Internal byte register file with registered read data
`timescale 1ns/10ps
module reg_byte_file (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       ce,
  input  wire [6:0] rd_addr,
  output reg  [7:0] rd_data,
  input  wire       wr_en,
  input  wire [6:0] wr_addr,
  input  wire [7:0] wr_data
);

  reg [7:0] mem [0:127];

  // Storage array, no reset so it maps onto memory cells
  always @(posedge clk) begin
    if (ce && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read data leave through a register
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (ce) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // reg_byte_file

// [core/script_io_rw_decode.v]
// I/O and read/write instruction decoder of the script processor
//
// Function
// RULE1 - Clear drops selected latch bits and carry
// RULE2 - Bit 9 sets or clears target mode
// RULE3 - Bit 26 makes alternate address pointer relative
// RULE4 - Software uses mode bits only on selections
// RULE5 - Bit 25 adds signed offset to base
// RULE6 - Table mode fetches ID, offset, period
// RULE7 - Table entry: config, ID, transfer, zero
// RULE8 - Table aligned, within 8 MB of base
// RULE9 - Addressing bits act independently of each other
// RULE10 - Table relative: first word offset, second jump
// RULE11 - Bit 24 gives select ATN, else illegal
// RULE12 - Destination ID from bits 18-16
// RULE13 - Bit 10 sets or clears carry
// RULE14 - Bit 6 ACK, bit 3 ATN latches
// RULE15 - Drive ACK/ATN only initiator or loopback
// RULE16 - Software sets ACK/ATN only for tests
// RULE17 - Reject message: ATN before clearing ACK
// RULE18 - Operator codes: load, logic, add, shifts
// RULE19 - Opcode 110 writes result into FBR
// RULE20 - Opcode 101 writes FBR result to register
// RULE21 - Shifts pass through the carry bit
// RULE22 - Opcode 111 writes result back to register
// RULE23 - Opcodes up to 100 are I/O
// RULE24 - Bits 22-16 select an internal register
`timescale 1ns/10ps
`include "script_decode_regs.vh"
module script_io_rw_decode (
  input  wire        CLK,
  input  wire        RST_N,
  input  wire        CE,
  input  wire        INST_VALID,
  output wire        INST_READY,
  input  wire [31:0] INST_W0,
  input  wire [31:0] INST_W1,
  input  wire [31:0] SCRIPT_PTR,
  input  wire [31:0] DATA_STRUCTURE_BASE,
  output reg         FETCH_REQ,
  output reg  [31:0] FETCH_ADDR,
  input  wire        FETCH_ACK,
  input  wire [31:0] FETCH_DATA,
  input  wire        FBR_LOAD,
  input  wire [7:0]  FBR_DATA,
  input  wire        LOOPBACK_EN,
  output reg         DONE,
  output reg         ILLEGAL_INST,
  output reg         SEL_REQUEST,
  output reg  [2:0]  SEL_OPCODE,
  output reg         SEL_WITH_ATN,
  output reg  [2:0]  DEST_ID,
  output reg  [7:0]  SCSI_CONTROL_THREE,
  output reg  [7:0]  SYNC_TRANSFER_REGISTER,
  output reg  [31:0] ALT_JUMP_ADDR,
  output reg         TARGET_MODE,
  output reg         CARRY,
  output reg         LATCH_ACK,
  output reg         LATCH_ATN,
  output wire        SCSI_ACK_OE_N,
  output wire        SCSI_ATN_OE_N,
  output reg  [7:0]  FIRST_BYTE_RECEIVED,
  output reg  [7:0]  RW_RESULT,
  output reg  [6:0]  RW_ADDR
);

  // Sign-extend a 24-bit offset and add it to a 32-bit base
  function [31:0] add_offset;
    input [31:0] base;
    input [23:0] ofs;
    begin
      add_offset = base + {{8{ofs[`OFS_SIGN]}}, ofs};
    end
  endfunction

  // Operator unit: returns {carry_out, result}
  function [8:0] alu;
    input [2:0] op;
    input [7:0] a;
    input [7:0] imm;
    input       cin;
    input       load_a;
    begin
      case (op)
        `ALU_LOAD: alu = {cin, (load_a ? a : imm)};
        `ALU_SHL:  alu = {a[7], a[6:0], cin};
        `ALU_OR:   alu = {cin, a | imm};
        `ALU_XOR:  alu = {cin, a ^ imm};
        `ALU_AND:  alu = {cin, a & imm};
        `ALU_SHR:  alu = {a[0], cin, a[7:1]};
        `ALU_ADD:  alu = {1'b0, a} + {1'b0, imm};
        `ALU_ADDC: alu = {1'b0, a} + {1'b0, imm} + {8'h00, cin};
        default:   alu = {cin, a};
      endcase
    end
  endfunction

  // Instruction field views
  wire [2:0]  opc      = INST_W0[`OPC_HI:`OPC_LO];
  wire        type_ok  = INST_W0[`TYPE_HI:`TYPE_LO] == `TYPE_IO_RW;
  wire        is_io    = type_ok && (opc <= `OPC_CLEAR); // [RULE23]
  wire        is_rw    = type_ok && (opc > `OPC_CLEAR);  // [RULE23]
  wire        take     = CE && INST_VALID && INST_READY;
  wire        rel_bit  = INST_W0[`BIT_REL];
  wire        tbl_bit  = INST_W0[`BIT_TABLE];
  wire        atn_bit  = INST_W0[`BIT_SEL_ATN];
  wire        selects  = (opc == `OPC_SELECT) || (opc == `OPC_WAIT_SEL);

  // One-hot sequencer states
  localparam ST_IDLE  = 4'h1;
  localparam ST_FETCH = 4'h2;
  localparam ST_READ  = 4'h4;
  localparam ST_WRITE = 4'h8;

  // One-hot sequencer state
  reg [3:0]  state;
  reg [3:0]  next_state;

  // Captured read/write instruction
  reg [2:0]  rw_op;
  reg [2:0]  rw_opc;
  reg [7:0]  rw_imm;

  // Register file port
  wire [7:0] reg_rdata;
  reg        reg_we;
  reg [7:0]  reg_wdata;
  reg [8:0]  alu_out;
  reg [7:0]  alu_a;

  assign INST_READY = state == ST_IDLE;

  // Initiator-only signals reach the bus in initiator or loopback
  assign SCSI_ACK_OE_N = ~(LATCH_ACK & (~TARGET_MODE | LOOPBACK_EN)); // [RULE15]
  assign SCSI_ATN_OE_N = ~(LATCH_ATN & (~TARGET_MODE | LOOPBACK_EN)); // [RULE15]

  // Next state choice
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take && is_io && selects && tbl_bit) begin
          next_state = ST_FETCH; // [RULE6]
        end else if (take && is_rw) begin
          next_state = ST_READ;
        end
      end
      ST_FETCH: begin
        if (FETCH_ACK) begin
          next_state = ST_IDLE;
        end
      end
      ST_READ: begin
        next_state = ST_WRITE;
      end
      ST_WRITE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // State register
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_IDLE;
    end else if (CE) begin
      state <= next_state;
    end
  end

  // Operand choice and operator result for the read/write class
  always @* begin
    if (rw_opc == `OPC_FROM_FBR) begin
      alu_a = FIRST_BYTE_RECEIVED; // [RULE20]
    end else begin
      alu_a = reg_rdata;           // [RULE19] [RULE22]
    end
    alu_out = alu(rw_op, alu_a, rw_imm, CARRY,
                  rw_opc == `OPC_FROM_FBR); // [RULE18] [RULE21]
    reg_we    = (state == ST_WRITE) && (rw_opc != `OPC_TO_FBR);
    reg_wdata = alu_out[7:0];
  end

  // Internal byte registers addressed by the 7-bit field
  reg_byte_file u_regs (
    .clk     (CLK),
    .rst_n   (RST_N),
    .ce      (CE),
    .rd_addr (RW_ADDR),
    .rd_data (reg_rdata),
    .wr_en   (reg_we),
    .wr_addr (RW_ADDR),
    .wr_data (reg_wdata)
  );

  // Capture of read/write fields at issue
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rw_op   <= 3'h0;
      rw_opc  <= 3'h0;
      rw_imm  <= `RST_BYTE;
      RW_ADDR <= 7'h00;
    end else if (CE && take && is_rw) begin
      rw_op   <= INST_W0[`ALU_OP_HI:`ALU_OP_LO];
      rw_opc  <= opc;
      rw_imm  <= INST_W0[`IMM_HI:`IMM_LO];
      RW_ADDR <= INST_W0[`REG_ADDR_HI:`REG_ADDR_LO]; // [RULE24]
    end
  end

  // First byte received: bus load, or move-to result
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      FIRST_BYTE_RECEIVED <= `RST_BYTE;
    end else if (CE) begin
      if (state == ST_WRITE && rw_opc == `OPC_TO_FBR) begin
        FIRST_BYTE_RECEIVED <= alu_out[7:0]; // [RULE19]
      end else if (FBR_LOAD) begin
        FIRST_BYTE_RECEIVED <= FBR_DATA;
      end
    end
  end

  // Result shown for every read/write instruction
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RW_RESULT <= `RST_BYTE;
    end else if (CE && state == ST_WRITE) begin
      RW_RESULT <= alu_out[7:0]; // [RULE20] [RULE22]
    end
  end

  // Carry: set/clear instructions and arithmetic or shift results
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CARRY <= 1'b0;
    end else if (CE) begin
      if (take && is_io && INST_W0[`BIT_CARRY]) begin
        if (opc == `OPC_SET) begin
          CARRY <= 1'b1; // [RULE13]
        end else if (opc == `OPC_CLEAR) begin
          CARRY <= 1'b0; // [RULE1] [RULE13]
        end
      end else if (state == ST_WRITE) begin
        CARRY <= alu_out[8]; // [RULE21]
      end
    end
  end

  // Target mode bit and output control latch bits
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      TARGET_MODE <= 1'b0;
      LATCH_ACK   <= 1'b0;
      LATCH_ATN   <= 1'b0;
    end else if (CE && take && is_io) begin
      if (opc == `OPC_SET) begin
        if (INST_W0[`BIT_TARGET]) TARGET_MODE <= 1'b1; // [RULE2]
        if (INST_W0[`BIT_ACK])    LATCH_ACK   <= 1'b1; // [RULE14]
        if (INST_W0[`BIT_ATN])    LATCH_ATN   <= 1'b1; // [RULE14]
      end else if (opc == `OPC_CLEAR) begin
        if (INST_W0[`BIT_TARGET]) TARGET_MODE <= 1'b0; // [RULE2]
        if (INST_W0[`BIT_ACK])    LATCH_ACK   <= 1'b0; // [RULE1]
        if (INST_W0[`BIT_ATN])    LATCH_ATN   <= 1'b0; // [RULE1]
      end
    end
  end

  // Alternate jump target: absolute, or pointer plus displacement
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ALT_JUMP_ADDR <= `RST_WORD;
    end else if (CE && take && is_io) begin
      if (rel_bit) begin
        ALT_JUMP_ADDR <= add_offset(SCRIPT_PTR,
                                    INST_W1[`OFS_HI:0]); // [RULE3] [RULE10]
      end else begin
        ALT_JUMP_ADDR <= INST_W1; // [RULE9]
      end
    end
  end

  // Table fetch: base plus signed offset from the first word
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      FETCH_REQ  <= 1'b0;
      FETCH_ADDR <= `RST_WORD;
    end else if (CE) begin
      if (take && is_io && selects && tbl_bit) begin
        FETCH_REQ  <= 1'b1; // [RULE6]
        FETCH_ADDR <= add_offset(DATA_STRUCTURE_BASE,
                                 INST_W0[`OFS_HI:0]); // [RULE5] [RULE10]
      end else if (state == ST_FETCH && FETCH_ACK) begin
        FETCH_REQ  <= 1'b0;
      end
    end
  end

  // Destination ID and transfer settings, direct or from the table
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      DEST_ID                <= 3'h0;
      SCSI_CONTROL_THREE     <= `RST_BYTE;
      SYNC_TRANSFER_REGISTER <= `RST_BYTE;
    end else if (CE) begin
      if (take && is_io && !(selects && tbl_bit)) begin
        DEST_ID <= INST_W0[`DEST_ID_HI:`DEST_ID_LO]; // [RULE12] [RULE9]
      end else if (state == ST_FETCH && FETCH_ACK) begin
        SCSI_CONTROL_THREE     <= FETCH_DATA[`TBL_CFG_HI:`TBL_CFG_LO];
        DEST_ID                <= FETCH_DATA[`TBL_ID_HI:`TBL_ID_LO];
        SYNC_TRANSFER_REGISTER <= FETCH_DATA[`TBL_XFER_HI:`TBL_XFER_LO];
      end // [RULE6] [RULE9]
    end
  end

  // Select-with-attention flag and the selection opcode
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SEL_WITH_ATN <= 1'b0;
      SEL_OPCODE   <= 3'h0;
    end else if (CE && take && is_io) begin
      SEL_WITH_ATN <= atn_bit && opc == `OPC_SELECT
                      && !TARGET_MODE; // [RULE11]
      SEL_OPCODE   <= opc;
    end
  end

  // Completion, selection request and illegal-instruction pulses
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      DONE         <= 1'b0;
      SEL_REQUEST  <= 1'b0;
      ILLEGAL_INST <= 1'b0;
    end else if (CE) begin
      DONE         <= (take && !(is_rw || (is_io && selects && tbl_bit)))
                      || (state == ST_FETCH && FETCH_ACK)
                      || state == ST_WRITE;
      SEL_REQUEST  <= (take && is_io && opc <= `OPC_WAIT_SEL
                       && !(selects && tbl_bit))
                      || (state == ST_FETCH && FETCH_ACK);
      ILLEGAL_INST <= take && is_io && atn_bit
                      && !(opc == `OPC_SELECT && !TARGET_MODE); // [RULE11]
    end
  end

endmodule // script_io_rw_decode

// [tb/decode_props.sv]
// Port-level checks of the script instruction decoder
`timescale 1ns/10ps
module decode_props (
  input wire        CLK,
  input wire        RST_N,
  input wire        CE,
  input wire        INST_VALID,
  input wire        INST_READY,
  input wire [31:0] INST_W0,
  input wire [31:0] INST_W1,
  input wire [31:0] SCRIPT_PTR,
  input wire [31:0] DATA_STRUCTURE_BASE,
  input wire        FETCH_REQ,
  input wire [31:0] FETCH_ADDR,
  input wire        FETCH_ACK,
  input wire [31:0] FETCH_DATA,
  input wire        LOOPBACK_EN,
  input wire        DONE,
  input wire        ILLEGAL_INST,
  input wire        SEL_REQUEST,
  input wire [2:0]  DEST_ID,
  input wire [31:0] ALT_JUMP_ADDR,
  input wire        TARGET_MODE,
  input wire        LATCH_ACK,
  input wire        SCSI_ACK_OE_N,
  input wire [7:0]  FIRST_BYTE_RECEIVED,
  input wire [7:0]  RW_RESULT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Taken instruction, its opcode and sign-extended offsets
  wire        take = CE && INST_VALID && INST_READY && INST_W0[31:30] == 2'h1;
  wire [2:0]  opc  = INST_W0[29:27];
  wire        io   = take && opc <= 3'h4;
  wire        sc   = io && (opc == 3'h3 || opc == 3'h4);
  wire [31:0] ofs  = {{8{INST_W0[23]}}, INST_W0[23:0]};
  wire [31:0] rel  = {{8{INST_W1[23]}}, INST_W1[23:0]};
  a_set_latch: assert property (
    io && opc == 3'h3 && INST_W0[6] |=> LATCH_ACK && DONE)
    else $error("ack latch not set");
  a_clear_latch: assert property (
    io && opc == 3'h4 && INST_W0[6] |=> !LATCH_ACK)
    else $error("ack latch not cleared");
  a_target_mode: assert property (
    sc && INST_W0[9] |=> TARGET_MODE == ($past(opc) == 3'h3))
    else $error("target mode wrong");
  a_dest_id: assert property (
    io && opc <= 3'h2 && !INST_W0[25] |=> DEST_ID == $past(INST_W0[18:16]))
    else $error("destination id wrong");
  a_rel_jump: assert property (
    io && INST_W0[26] |=> ALT_JUMP_ADDR == $past(SCRIPT_PTR) + $past(rel))
    else $error("relative jump wrong");
  a_fetch_addr: assert property (
    io && (opc == 3'h0 || opc == 3'h2) && INST_W0[25] |=> FETCH_REQ &&
    FETCH_ADDR == $past(DATA_STRUCTURE_BASE) + $past(ofs))
    else $error("fetch address wrong");
  a_table_load: assert property (
    FETCH_REQ && FETCH_ACK |=> DONE && SEL_REQUEST &&
    DEST_ID == $past(FETCH_DATA[10:8]))
    else $error("table id not loaded");
  a_bit24_bad: assert property (
    io && INST_W0[24] && opc != 3'h0 |=> ILLEGAL_INST)
    else $error("illegal flag missing");
  a_rw_latency: assert property (
    take && opc >= 3'h5 |-> ##1 !DONE ##1 !DONE ##1 DONE)
    else $error("read/write latency wrong");
  a_rw_fbr: assert property (
    take && opc == 3'h6 |-> ##3 FIRST_BYTE_RECEIVED == RW_RESULT)
    else $error("fbr not written");
  a_ack_drive: assert property (
    SCSI_ACK_OE_N == !(LATCH_ACK && (!TARGET_MODE || LOOPBACK_EN)))
    else $error("ack drive wrong");
  c_table: cover property (FETCH_REQ && FETCH_ACK);
  c_rw: cover property (take && opc >= 3'h5);
  c_bad: cover property (ILLEGAL_INST);
endmodule // decode_props

bind script_io_rw_decode decode_props i_props (.*);

// [tb/mem_responder.sv]
// Host memory model answering selection table fetches
`timescale 1ns/10ps
module mem_responder (
  input  wire        clk,
  input  wire        req,
  input  wire [31:0] entry,
  input  wire [3:0]  lat,
  output reg         ack,
  output reg  [31:0] data
);
  reg [3:0] cnt;
  initial begin
    ack = 1'b0;
    data = 32'h00000000;
    cnt = 4'h0;
  end
  // Ack a held request after lat cycles; idle data toggles, never stale
  always @(posedge clk) begin
    ack <= 1'b0;
    data <= ~data;
    if (req && !ack) begin
      if (cnt >= lat) begin
        ack <= 1'b1;
        data <= entry;
        cnt <= 4'h0;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule // mem_responder

// [tb/tb.sv]
// Self-checking bench of the script instruction decoder
`timescale 1ns/10ps
module tb;
  logic        CLK = 1'b0, RST_N = 1'b0, CE = 1'b1, INST_VALID = 1'b0;
  logic        FBR_LOAD = 1'b0, LOOPBACK_EN = 1'b0, ill;
  logic [7:0]  FBR_DATA = 8'h00;
  logic [31:0] INST_W0 = 32'h0, INST_W1 = 32'h0, SCRIPT_PTR = 32'h0;
  logic [31:0] DATA_STRUCTURE_BASE = 32'h0, entry = 32'h0;
  logic [3:0]  lat = 4'h0;
  int          err_count = 0, check_count = 0;
  wire         INST_READY, FETCH_REQ, FETCH_ACK, DONE, ILLEGAL_INST;
  wire         SEL_REQUEST, SEL_WITH_ATN, TARGET_MODE, CARRY, LATCH_ACK;
  wire         LATCH_ATN, SCSI_ACK_OE_N, SCSI_ATN_OE_N;
  wire [2:0]   DEST_ID, SEL_OPCODE;
  wire [6:0]   RW_ADDR;
  wire [7:0]   SCSI_CONTROL_THREE, SYNC_TRANSFER_REGISTER;
  wire [7:0]   FIRST_BYTE_RECEIVED, RW_RESULT;
  wire [31:0]  FETCH_ADDR, FETCH_DATA, ALT_JUMP_ADDR;
  wire [3:0]   flags = {TARGET_MODE, CARRY, LATCH_ACK, LATCH_ATN};
  wire [1:0]   oe_n = {SCSI_ACK_OE_N, SCSI_ATN_OE_N};
  wire [23:0]  tbl_seen = {SYNC_TRANSFER_REGISTER, 5'h00, DEST_ID,
                           SCSI_CONTROL_THREE};
  typedef struct packed {
    logic [31:0] w0;
    logic [3:0]  f;
    logic [7:0]  r;
  } row_t;
  // Set/clear steps, then every operator in sequence through two registers, then moves via FBR
  row_t rows [16] = '{
    '{32'h58000648, 4'hf, 8'h00}, '{32'h60000040, 4'hd, 8'h00},
    '{32'h60000208, 4'h4, 8'h00}, '{32'h60000400, 4'h0, 8'h00},
    '{32'h58000008, 4'h1, 8'h00}, '{32'h78128100, 4'h1, 8'h81},
    '{32'h79120000, 4'h5, 8'h02}, '{32'h7f12fe00, 4'h5, 8'h01},
    '{32'h7e12ff00, 4'h5, 8'h00}, '{32'h7d120000, 4'h1, 8'h80},
    '{32'h72120f00, 4'h1, 8'h8f}, '{32'h6b21ff00, 4'h1, 8'h70},
    '{32'h6c210f00, 4'h1, 8'h0f}, '{32'h70005500, 4'h1, 8'h55},
    '{32'h72210000, 4'h1, 8'h0f}, '{32'h68300000, 4'h1, 8'h0f}};
  script_io_rw_decode i_dut (.*);
  mem_responder i_mem (.clk(CLK), .req(FETCH_REQ), .entry(entry),
                       .lat(lat), .ack(FETCH_ACK), .data(FETCH_DATA));
  always #25 CLK = ~CLK;
  task chk(string n, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Offer one instruction, drop valid once taken, wait for done
  task run(logic [31:0] w0, logic [31:0] w1);
    int n;
    n = 0;
    @(posedge CLK);
    INST_W0 <= w0;
    INST_W1 <= w1;
    INST_VALID <= 1'b1;
    @(posedge CLK);
    INST_VALID <= 1'b0;
    #1;
    while (DONE !== 1'b1 && n < 20) begin
      @(posedge CLK);
      #1;
      n++;
    end
    ill = ILLEGAL_INST;
    chk("done", 1'b1, DONE);
  endtask
  // Table-mode select with the memory answering after l cycles
  task tbl(logic [31:0] w0, w1, e, a, j, logic [3:0] l);
    @(posedge CLK);
    DATA_STRUCTURE_BASE <= 32'h00010000;
    entry <= e;
    lat <= l;
    run(w0, w1);
    chk("fetch_addr", a, FETCH_ADDR);
    chk("alt", j, ALT_JUMP_ADDR);
    chk("table", e[23:0], tbl_seen);
  endtask
  task summarize;
    if (err_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    summarize;
  end
  // Main sequence: reset, table rows, then the awkward cases
  initial begin
    repeat (5) @(posedge CLK);
    RST_N <= 1'b1;
    #1;
    chk("flags", 4'h0, flags);
    @(posedge CLK);
    FBR_DATA <= 8'h3c;
    FBR_LOAD <= 1'b1;
    @(posedge CLK);
    FBR_LOAD <= 1'b0;
    #1;
    chk("fbr", 8'h3c, FIRST_BYTE_RECEIVED);
    foreach (rows[i]) begin
      run(rows[i].w0, 32'h0);
      chk("flags", rows[i].f, flags);
      if (rows[i].w0[29:27] >= 3'h5)
        chk("result", rows[i].r, RW_RESULT);
      if (rows[i].w0[29:27] >= 3'h5)
        chk("rw_addr", rows[i].w0[22:16], RW_ADDR);
      if (rows[i].w0[29:27] == 3'h6)
        chk("fbr", rows[i].r, FIRST_BYTE_RECEIVED);
    end
    run(32'h41050000, 32'h00001000);
    chk("dest", 3'h5, DEST_ID);
    chk("sel_atn", 1'b1, SEL_WITH_ATN);
    chk("illegal", 1'b0, ill);
    chk("alt", 32'h00001000, ALT_JUMP_ADDR);
    @(posedge CLK);
    SCRIPT_PTR <= 32'h00002000;
    run(32'h55030000, 32'h00fffff0);
    chk("illegal", 1'b1, ill);
    chk("alt", 32'h00001ff0, ALT_JUMP_ADDR);
    chk("sel_opc", 3'h2, SEL_OPCODE);
    tbl(32'h46fffff8, 32'h100, 32'hd306a7, 32'hfff8, 32'h2100, 4'h3);
    tbl(32'h52000010, 32'h3000, 32'h4c0215, 32'h10010, 32'h3000, 4'h0);
    run(32'h58000040, 32'h0);
    chk("oe_n", 2'h0, oe_n);
    run(32'h58000208, 32'h0);
    chk("oe_n", 2'h3, oe_n);
    @(posedge CLK);
    LOOPBACK_EN <= 1'b1;
    @(posedge CLK);
    #1;
    chk("oe_n", 2'h0, oe_n);
    @(posedge CLK);
    LOOPBACK_EN <= 1'b0;
    run(32'h60000240, 32'h0);
    chk("oe_n", 2'h2, oe_n);
    run(32'h60000008, 32'h0);
    chk("oe_n", 2'h3, oe_n);
    run(32'h58000648, 32'h0);
    @(posedge CLK);
    RST_N <= 1'b0;
    #1;
    chk("flags", 4'h0, flags);
    chk("ready", 1'b1, INST_READY);
    chk("oe_n", 2'h3, oe_n);
    @(posedge CLK);
    RST_N <= 1'b1;
    // Clock enable low: an offered set-carry must not be taken
    CE <= 1'b0;
    INST_W0 <= 32'h58000400;
    INST_VALID <= 1'b1;
    repeat (3) @(posedge CLK);
    #1;
    chk("frozen", 5'h00, {flags, DONE});
    @(posedge CLK);
    CE <= 1'b1;
    INST_VALID <= 1'b0;
    // Register contents survive reset; this one was moved from FBR
    run(32'h72300000, 32'h0);
    chk("fbr", 8'h0f, FIRST_BYTE_RECEIVED);
    summarize;
  end
endmodule // tb
